/* File: design/lmfe_frontend.sv */
// Shared line-test level meter front end with AXI4-Lite control
//
// How it works
// - One meter, two-bit field picks channel
// - Source type 1 meters transmit AC signal
// - Source type 0: DC path bit picks rx/tx
// - Code 0000 tip DC sense, reset default
// - Code 0100 feed loop differential output
// - Codes 1001-1011 line, pin three, four
// - Codes 1100,1101,1111 ring-trip, half supply, difference
// - Code 1110 offset, common-mode reference connected
// - AC metering runs beside speech, 8 kHz
// - Filter enable 0 bypasses, 1 inserts on AC source only
// - Shape bit: 0 notch, 1 bandpass
// - Coefficient source bit: 0 RAM, 1 ROM
// - Quality 5, default centre 1014 Hz
// - DC transmit samples arrive at 8 kHz
// - Offset register added to DC transmit samples
// - Gain bit: 0 times one, 1 times sixteen
// - Rectifier bit 1 makes negatives positive
`timescale 1ns/1ns
module lmfe_frontend (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address
   input wire logic [7:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [7:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // 8 kHz sample tick shared by all channel paths
   input wire logic sample_strobe,
   // Per-channel samples, channel n in bits [16n+15:16n]
   input wire logic [63:0] tip_ac_sense,
   input wire logic [63:0] rx_dc_sample,
   input wire logic [63:0] tip_dc_sense,
   input wire logic [63:0] feed_loop_diff_output,
   input wire logic [63:0] line_voltage_sense,
   input wire logic [63:0] gp_pin_three,
   input wire logic [63:0] gp_pin_four,
   input wire logic [63:0] ring_trip_input,
   input wire logic [63:0] half_supply_sense,
   input wire logic [63:0] offset_sense,
   // Metered stream towards the integrator
   output logic meter_valid,
   output logic [15:0] meter_sample,
   // Analog mux steering for the selected channel
   output logic [1:0] meter_channel_select,
   output logic [3:0] dc_input_select,
   output logic common_mode_reference
);

   localparam int N = lmfe_pkg::NUM_CH;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic aw_have;
      logic w_have;
      logic [7:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic [1:0] chan;
      logic [15:0] ram_c1;
      logic [15:0] ram_c2;
      logic [N-1:0][3:0] source;
      logic [N-1:0][3:0] select;
      logic [N-1:0][1:0] gain;
      logic [N-1:0][1:0] csrc;
      logic [N-1:0][15:0] offset;
      logic s1_valid;
      logic [15:0] s1_data;
      logic s1_filt;
      logic s1_shape;
      logic s1_rom;
      logic s1_gain;
      logic s1_rect;
      logic s2_gain;
      logic s2_rect;
      logic out_valid;
      logic [15:0] out_data;
      logic [3:0] dc_code;
      logic cm_ref;
   } lmfe_state_t;

   lmfe_state_t s_q, s_d;

   logic f_valid;
   logic signed [15:0] f_data;
   logic signed [15:0] c1_sel;
   logic signed [15:0] c2_sel;

   // Merge byte lanes of a write into a register word
   function automatic logic [15:0] lmfe_merge(
      input logic [15:0] old,
      input logic [31:0] data,
      input logic [3:0] strb
   );
      logic [15:0] r;
      r = old;
      if (strb[0]) begin
         r[7:0] = data[7:0];
      end
      if (strb[1]) begin
         r[15:8] = data[15:8];
      end
      return r;
   endfunction : lmfe_merge

   // True when an address hits a channel block
   function automatic logic lmfe_is_chan(input logic [7:0] a);
      return a[7:5] >= lmfe_pkg::CH_BLOCK_FIRST &&
         a[7:5] <= lmfe_pkg::CH_BLOCK_LAST &&
         a[4:2] <= lmfe_pkg::IDX_OFFSET && a[1:0] == 2'h0;
   endfunction : lmfe_is_chan

   // Channel slot of an address inside the channel blocks
   function automatic logic [1:0] lmfe_slot(input logic [7:0] a);
      return 2'(a[7:5] - lmfe_pkg::CH_BLOCK_FIRST);
   endfunction : lmfe_slot

   // One signed sample of a flattened per-channel bus
   function automatic logic signed [15:0] lmfe_pick(
      input logic [63:0] bus,
      input logic [1:0] ch
   );
      return bus[16 * ch +: 16];
   endfunction : lmfe_pick

   // Read decode; unmapped answers zero
   function automatic logic [31:0] lmfe_read(
      input lmfe_state_t s,
      input logic [7:0] a
   );
      logic [1:0] c;
      c = lmfe_slot(a);
      lmfe_read = 32'h0000_0000;
      if (a == lmfe_pkg::ADDR_GLOBAL) begin
         lmfe_read = {30'h0, s.chan};
      end else if (a == lmfe_pkg::ADDR_STATUS) begin
         lmfe_read = {16'h0000, s.out_data};
      end else if (a == lmfe_pkg::ADDR_RAM_C1) begin
         lmfe_read = {16'h0000, s.ram_c1};
      end else if (a == lmfe_pkg::ADDR_RAM_C2) begin
         lmfe_read = {16'h0000, s.ram_c2};
      end else if (lmfe_is_chan(a)) begin
         case (a[4:2])
            lmfe_pkg::IDX_SOURCE: lmfe_read = {28'h0, s.source[c]};
            lmfe_pkg::IDX_SELECT: lmfe_read = {28'h0, s.select[c]};
            lmfe_pkg::IDX_GAIN: lmfe_read = {30'h0, s.gain[c]};
            lmfe_pkg::IDX_COEF_SRC: lmfe_read = {30'h0, s.csrc[c]};
            default: lmfe_read = {16'h0000, s.offset[c]};
         endcase
      end
   endfunction : lmfe_read

   // Register bus, sample capture and output stage
   always_comb begin
      logic [1:0] wc;
      logic [1:0] ch;
      logic [3:0] src;
      logic signed [15:0] raw;
      logic signed [15:0] dc;
      logic signed [15:0] g;
      logic [3:0] code;
      logic ok;
      wc = lmfe_slot(s_q.awaddr);
      ch = s_q.chan;
      src = s_q.source[ch];
      code = s_q.select[ch];
      raw = '0;
      dc = '0;
      g = '0;
      ok = 1'b0;
      s_d = s_q;

      // Address and data are taken in either order, then answered together
      if (s_axi_awvalid && s_q.awready) begin
         s_d.aw_have = 1'b1;
         s_d.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_q.wready) begin
         s_d.w_have = 1'b1;
         s_d.wdata = s_axi_wdata;
         s_d.wstrb = s_axi_wstrb;
      end
      if (s_q.bvalid && s_axi_bready) begin
         s_d.bvalid = 1'b0;
      end
      if (s_q.aw_have && s_q.w_have && !s_q.bvalid) begin
         s_d.aw_have = 1'b0;
         s_d.w_have = 1'b0;
         s_d.bvalid = 1'b1;
         ok = 1'b1;
         if (s_q.awaddr == lmfe_pkg::ADDR_GLOBAL) begin
            if (s_q.wstrb[0]) begin
               s_d.chan = s_q.wdata[1:0];
            end
         end else if (s_q.awaddr == lmfe_pkg::ADDR_RAM_C1) begin
            s_d.ram_c1 = lmfe_merge(s_q.ram_c1, s_q.wdata, s_q.wstrb);
         end else if (s_q.awaddr == lmfe_pkg::ADDR_RAM_C2) begin
            s_d.ram_c2 = lmfe_merge(s_q.ram_c2, s_q.wdata, s_q.wstrb);
         end else if (lmfe_is_chan(s_q.awaddr) && s_q.wstrb[0]) begin
            case (s_q.awaddr[4:2])
               lmfe_pkg::IDX_SOURCE: s_d.source[wc] = s_q.wdata[3:0];
               lmfe_pkg::IDX_SELECT: s_d.select[wc] = s_q.wdata[3:0];
               lmfe_pkg::IDX_GAIN: s_d.gain[wc] = s_q.wdata[1:0];
               lmfe_pkg::IDX_COEF_SRC: s_d.csrc[wc] = s_q.wdata[1:0];
               default: s_d.offset[wc] = lmfe_merge(s_q.offset[wc],
                  s_q.wdata, s_q.wstrb);
            endcase
         end else if (lmfe_is_chan(s_q.awaddr)) begin
            if (s_q.awaddr[4:2] == lmfe_pkg::IDX_OFFSET) begin
               s_d.offset[wc] = lmfe_merge(s_q.offset[wc], s_q.wdata,
                  s_q.wstrb);
            end
         end else if (s_q.awaddr != lmfe_pkg::ADDR_STATUS) begin
            ok = 1'b0;
         end
         s_d.bresp = ok ? lmfe_pkg::RESP_OKAY : lmfe_pkg::RESP_SLVERR;
      end
      // Ready drops while a half of a write waits or the answer is pending
      s_d.awready = !s_d.aw_have && !s_d.bvalid;
      s_d.wready = !s_d.w_have && !s_d.bvalid;

      // Reads: one outstanding, answered the cycle after the address
      if (s_q.rvalid && s_axi_rready) begin
         s_d.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_q.arready) begin
         s_d.rvalid = 1'b1;
         s_d.rdata = lmfe_read(s_q, s_axi_araddr);
         ok = s_axi_araddr == lmfe_pkg::ADDR_GLOBAL ||
            s_axi_araddr == lmfe_pkg::ADDR_STATUS ||
            s_axi_araddr == lmfe_pkg::ADDR_RAM_C1 ||
            s_axi_araddr == lmfe_pkg::ADDR_RAM_C2 ||
            lmfe_is_chan(s_axi_araddr);
         s_d.rresp = ok ? lmfe_pkg::RESP_OKAY : lmfe_pkg::RESP_SLVERR;
      end
      s_d.arready = !s_d.rvalid;

      // DC transmit mux; unlisted codes give zero, so only the offset trim is metered
      case (code)
         lmfe_pkg::LMFE_DC_TIP: dc = lmfe_pick(tip_dc_sense, ch);
         lmfe_pkg::LMFE_DC_FEED_DIFF:
            dc = lmfe_pick(feed_loop_diff_output, ch);
         lmfe_pkg::LMFE_DC_LINE:
            dc = lmfe_pick(line_voltage_sense, ch);
         lmfe_pkg::LMFE_DC_GP3: dc = lmfe_pick(gp_pin_three, ch);
         lmfe_pkg::LMFE_DC_GP4: dc = lmfe_pick(gp_pin_four, ch);
         lmfe_pkg::LMFE_DC_RING_TRIP:
            dc = lmfe_pick(ring_trip_input, ch);
         lmfe_pkg::LMFE_DC_HALF_SUPPLY:
            dc = lmfe_pick(half_supply_sense, ch);
         lmfe_pkg::LMFE_DC_OFFSET: dc = lmfe_pick(offset_sense, ch);
         lmfe_pkg::LMFE_DC_GP_DIFF: dc = lmfe_pkg::lmfe_sat(
            36'(lmfe_pick(gp_pin_four, ch)) -
            36'(lmfe_pick(gp_pin_three, ch)));
         default: dc = '0;
      endcase

      // Source choice; AC ignores the DC path bit and input code
      if (src[lmfe_pkg::POS_SOURCE_TYPE]) begin
         raw = lmfe_pick(tip_ac_sense, ch);
      end else if (!src[lmfe_pkg::POS_DC_PATH]) begin
         raw = lmfe_pick(rx_dc_sample, ch);
      end else begin
         // Offset trim cancels the converter's own error
         raw = lmfe_pkg::lmfe_sat(36'(dc) +
            36'($signed(s_q.offset[ch])));
      end

      // Settings are sampled only on the tick, so writes land next sample
      s_d.s1_valid = sample_strobe;
      if (sample_strobe) begin
         s_d.s1_data = raw;
         s_d.s1_filt = src[lmfe_pkg::POS_SOURCE_TYPE] &
            src[lmfe_pkg::POS_FILTER_EN];
         s_d.s1_shape = src[lmfe_pkg::POS_SHAPE];
         s_d.s1_rom = src[lmfe_pkg::POS_SHAPE] ?
            s_q.csrc[ch][lmfe_pkg::POS_PASS_SRC] :
            s_q.csrc[ch][lmfe_pkg::POS_REJECT_SRC];
         s_d.s1_gain = s_q.gain[ch][lmfe_pkg::POS_EXTRA_GAIN];
         s_d.s1_rect = s_q.gain[ch][lmfe_pkg::POS_RECT_EN];
      end
      if (s_q.s1_valid) begin
         s_d.s2_gain = s_q.s1_gain;
         s_d.s2_rect = s_q.s1_rect;
      end

      // Gain then rectifier; both saturate rather than wrap
      s_d.out_valid = f_valid;
      if (f_valid) begin
         g = s_q.s2_gain ? lmfe_pkg::lmfe_sat(36'(f_data) <<< 4) :
            f_data;
         if (s_q.s2_rect && g[15]) begin
            s_d.out_data = lmfe_pkg::lmfe_sat(-36'(g));
         end else begin
            s_d.out_data = g;
         end
      end

      // Analog steering follows the selected channel's settings
      s_d.dc_code = code;
      s_d.cm_ref = !src[lmfe_pkg::POS_SOURCE_TYPE] &&
         src[lmfe_pkg::POS_DC_PATH] &&
         code == lmfe_pkg::LMFE_DC_OFFSET;
   end

   // Coefficients: ROM holds the default centre, RAM is user-loaded
   always_comb begin
      c1_sel = s_q.s1_rom ? lmfe_pkg::ROM_C1 : s_q.ram_c1;
      c2_sel = s_q.s1_rom ? lmfe_pkg::ROM_C2 : s_q.ram_c2;
   end

   lmfe_resonator u_resonator (
      .aclk(aclk),
      .aresetn(aresetn),
      .in_valid(s_q.s1_valid),
      .in_sample(s_q.s1_data),
      .filt_en(s_q.s1_filt),
      .shape_pass(s_q.s1_shape),
      .c1(c1_sel),
      .c2(c2_sel),
      .out_valid(f_valid),
      .out_sample(f_data)
   );

   // State register with reset defaults
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q <= '0;
         s_q.awready <= 1'b1;
         s_q.wready <= 1'b1;
         s_q.arready <= 1'b1;
         s_q.chan <= lmfe_pkg::RST_CHAN;
         s_q.ram_c1 <= lmfe_pkg::RST_RAM_COEF;
         s_q.ram_c2 <= lmfe_pkg::RST_RAM_COEF;
         s_q.source <= {N{lmfe_pkg::RST_SOURCE}};
         s_q.select <= {N{lmfe_pkg::RST_SELECT}};
         s_q.gain <= {N{lmfe_pkg::RST_GAIN}};
         s_q.csrc <= {N{lmfe_pkg::RST_COEF_SRC}};
         s_q.offset <= {N{lmfe_pkg::RST_OFFSET}};
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs straight from the state register
   assign s_axi_awready = s_q.awready;
   assign s_axi_wready = s_q.wready;
   assign s_axi_bvalid = s_q.bvalid;
   assign s_axi_bresp = s_q.bresp;
   assign s_axi_arready = s_q.arready;
   assign s_axi_rvalid = s_q.rvalid;
   assign s_axi_rresp = s_q.rresp;
   assign s_axi_rdata = s_q.rdata;
   assign meter_valid = s_q.out_valid;
   assign meter_sample = s_q.out_data;
   assign meter_channel_select = s_q.chan;
   assign dc_input_select = s_q.dc_code;
   assign common_mode_reference = s_q.cm_ref;

endmodule : lmfe_frontend

/* File: pkg/lmfe_pkg.sv */
// Constants, register map and shared arithmetic of the level meter front end
package lmfe_pkg;

   // Datapath and channel count
   localparam int SAMPLE_W = 16;
   localparam int NUM_CH = 4;
   localparam int ADDR_W = 8;

   // Global register byte addresses
   localparam logic [7:0] ADDR_GLOBAL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_RAM_C1 = 8'h08;
   localparam logic [7:0] ADDR_RAM_C2 = 8'h0c;

   // Channel register blocks: addr[7:5] = channel + 1, addr[4:2] = index
   localparam logic [2:0] CH_BLOCK_FIRST = 3'h1;
   localparam logic [2:0] CH_BLOCK_LAST = 3'h4;
   localparam logic [2:0] IDX_SOURCE = 3'h0;
   localparam logic [2:0] IDX_SELECT = 3'h1;
   localparam logic [2:0] IDX_GAIN = 3'h2;
   localparam logic [2:0] IDX_COEF_SRC = 3'h3;
   localparam logic [2:0] IDX_OFFSET = 3'h4;

   // Field positions in the source register
   localparam int POS_SOURCE_TYPE = 0;
   localparam int POS_DC_PATH = 1;
   localparam int POS_FILTER_EN = 2;
   localparam int POS_SHAPE = 3;
   // Field positions in the gain register
   localparam int POS_EXTRA_GAIN = 0;
   localparam int POS_RECT_EN = 1;
   // Field positions in the coefficient source register
   localparam int POS_REJECT_SRC = 0;
   localparam int POS_PASS_SRC = 1;

   // Reset values
   localparam logic [3:0] RST_SOURCE = 4'h2;
   localparam logic [3:0] RST_SELECT = 4'h0;
   localparam logic [1:0] RST_GAIN = 2'h0;
   localparam logic [1:0] RST_COEF_SRC = 2'h3;
   localparam logic [15:0] RST_OFFSET = 16'h0000;
   localparam logic [15:0] RST_RAM_COEF = 16'h0000;
   localparam logic [1:0] RST_CHAN = 2'h0;

   // Built-in coefficients, Q14: centre 1014 Hz, quality factor 5
   localparam logic [15:0] ROM_C1 = 16'h52a8;
   localparam logic [15:0] ROM_C2 = 16'h3692;
   localparam logic [16:0] Q14_ONE = 17'h04000;
   localparam int Q14_SHIFT = 14;

   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // DC transmit input codes
   typedef enum logic [3:0] {
      LMFE_DC_TIP = 4'h0,
      LMFE_DC_FEED_DIFF = 4'h4,
      LMFE_DC_LINE = 4'h9,
      LMFE_DC_GP3 = 4'ha,
      LMFE_DC_GP4 = 4'hb,
      LMFE_DC_RING_TRIP = 4'hc,
      LMFE_DC_HALF_SUPPLY = 4'hd,
      LMFE_DC_OFFSET = 4'he,
      LMFE_DC_GP_DIFF = 4'hf
   } lmfe_dc_code_t;

   // Clamp a wide signed value into one sample
   function automatic logic signed [15:0] lmfe_sat(
      input logic signed [35:0] v
   );
      if (v > 36'sd32767) begin
         return 16'sh7fff;
      end else if (v < -36'sd32768) begin
         return 16'sh8000;
      end else begin
         return v[15:0];
      end
   endfunction : lmfe_sat

endpackage : lmfe_pkg

/* File: design/lmfe_resonator.sv */
// Second-order notch or bandpass stage with fixed quality factor
`timescale 1ns/1ns
module lmfe_resonator (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Sample in
   input wire logic in_valid,
   input wire logic signed [15:0] in_sample,
   // Settings captured with the sample
   input wire logic filt_en,
   input wire logic shape_pass,
   input wire logic signed [15:0] c1,
   input wire logic signed [15:0] c2,
   // Sample out
   output logic out_valid,
   output logic signed [15:0] out_sample
);

   typedef struct packed {
      logic signed [15:0] x1;
      logic signed [15:0] x2;
      logic signed [15:0] y1;
      logic signed [15:0] y2;
      logic valid;
      logic signed [15:0] out;
   } lmfe_res_state_t;

   lmfe_res_state_t s_q, s_d;

   logic signed [16:0] diff;
   logic signed [16:0] gain_q14;
   logic signed [35:0] acc;
   logic signed [15:0] pass_y;
   logic signed [15:0] reject_y;

   // Bandpass core; notch is input minus bandpass, so both share one state
   always_comb begin
      diff = 17'(in_sample) - 17'(s_q.x2);
      gain_q14 = (lmfe_pkg::Q14_ONE - 17'(c2)) >>> 1;
      // Widen before multiplying so the products keep every bit
      acc = 36'(gain_q14) * 36'(diff) + 36'(c1) * 36'(s_q.y1) -
         36'(c2) * 36'(s_q.y2);
      pass_y = lmfe_pkg::lmfe_sat(acc >>> lmfe_pkg::Q14_SHIFT);
      reject_y = lmfe_pkg::lmfe_sat(36'(in_sample) - 36'(pass_y));
      s_d = s_q;
      s_d.valid = in_valid;
      if (in_valid) begin
         if (filt_en) begin
            s_d.x1 = in_sample;
            s_d.x2 = s_q.x1;
            s_d.y1 = pass_y;
            s_d.y2 = s_q.y1;
            s_d.out = shape_pass ? pass_y : reject_y;
         end else begin
            // Bypass also flushes history so a later enable starts clean
            s_d.x1 = '0;
            s_d.x2 = '0;
            s_d.y1 = '0;
            s_d.y2 = '0;
            s_d.out = in_sample;
         end
      end
   end

   // State register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign out_valid = s_q.valid;
   assign out_sample = s_q.out;

endmodule : lmfe_resonator

/* File: verif/lmfe_sample_src.sv */
// Stand-in for the per-channel decimated sample paths
`timescale 1ns/1ns
module lmfe_sample_src (
   // Clock, reset and tick request
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic fire,
   // Tick and samples towards the meter
   output logic sample_strobe,
   output logic [63:0] src [10]
);
   int seed = 32'h461a;
   initial begin
      sample_strobe = 1'b0;
      for (int i = 0; i < 10; i++) src[i] = 64'h0;
   end
   // Fresh samples with the tick, inverted after it so stale data shows
   always @(posedge aclk) begin
      sample_strobe <= fire && aresetn;
      for (int i = 0; i < 10; i++) begin
         if (fire) src[i] <= {$random(seed), $random(seed)};
         else src[i] <= ~src[i];
      end
   end
endmodule : lmfe_sample_src

/* File: verif/lmfe_frontend_assertions.sv */
// Port-level checker for the level meter front end
`timescale 1ns/1ns
module lmfe_checker (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Bus handshakes
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   // Sample stream and steering
   input wire logic sample_strobe,
   input wire logic meter_valid,
   input wire logic [15:0] meter_sample,
   input wire logic [1:0] meter_channel_select,
   input wire logic [3:0] dc_input_select,
   input wire logic common_mode_reference
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   AST_METER_LATENCY: assert property (
      sample_strobe |-> ##3 meter_valid) else $error("late sample");
   AST_METER_CAUSE: assert property (
      meter_valid |-> $past(sample_strobe, 3)) else $error("stray sample");
   AST_METER_HOLD: assert property (
      !meter_valid |-> $stable(meter_sample)) else $error("sample moved");
   AST_METER_PULSE: assert property (
      meter_valid |=> !meter_valid) else $error("valid too long");
   AST_CMR_CODE: assert property (
      $rose(common_mode_reference) |-> ##[0:1] dc_input_select == 4'he)
      else $error("reference without offset code");
   AST_WRITE_RESP: assert property (
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> !s_axi_awready ##1 s_axi_bvalid) else $error("write answer");
   AST_READ_RESP: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("read answer");
   AST_CHAN_COMMIT: assert property (
      $changed(meter_channel_select) |-> $rose(s_axi_bvalid))
      else $error("channel moved without write");
endmodule : lmfe_checker

bind lmfe_frontend lmfe_checker lmfe_checker_i (.aclk, .aresetn,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
   .sample_strobe, .meter_valid, .meter_sample, .meter_channel_select,
   .dc_input_select, .common_mode_reference);

/* File: verif/lmfe_frontend_bench.sv */
// Self-checking bench for the level meter front end
`timescale 1ns/1ns
module lmfe_frontend_bench;
   logic aclk = 0, aresetn = 0, fire = 0, sample_strobe;
   logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
   logic s_axi_bready = 1, s_axi_rready = 1;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, meter_valid, common_mode_reference;
   logic [1:0] s_axi_bresp, s_axi_rresp, meter_channel_select, ch = 0;
   logic [15:0] meter_sample, off = 0, last = 0;
   logic [3:0] dc_input_select, code = 0;
   logic [63:0] src [10];
   logic st = 0, dp = 1, gn = 0, rc = 0, fl = 0;
   logic [31:0] r;
   logic [15:0] q [$];
   logic [7:0] base;
   int seed = 32'h461a, n_fail = 0, num_checks = 0, h1 = 0, h2 = 0;
   int map [16] = '{2,-1,-1,-1,3,-1,-1,-1,-1,4,5,6,7,8,9,-1};

   always #50 aclk = ~aclk;

   lmfe_sample_src lmfe_sample_src_i (.aclk, .aresetn, .fire,
      .sample_strobe, .src);
   lmfe_frontend lmfe_frontend_i (.aclk, .aresetn, .s_axi_awaddr,
      .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .sample_strobe,
      .tip_ac_sense(src[0]), .rx_dc_sample(src[1]),
      .tip_dc_sense(src[2]), .feed_loop_diff_output(src[3]),
      .line_voltage_sense(src[4]), .gp_pin_three(src[5]),
      .gp_pin_four(src[6]), .ring_trip_input(src[7]),
      .half_supply_sense(src[8]), .offset_sense(src[9]), .meter_valid,
      .meter_sample, .meter_channel_select, .dc_input_select,
      .common_mode_reference);

   task automatic summarize;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : summarize

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
   endtask : check

   task automatic tmo(input int k);
      if (k >= 100) begin
         n_fail++;
         summarize();
      end
   endtask : tmo

   // Bus write; bready stays high so the answer is taken on sight
   task automatic axw(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] e);
      int k;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      for (k = 0; k < 100; k++) begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      tmo(k);
      check({30'h0, s_axi_bresp}, {30'h0, e});
   endtask : axw

   // Bus read with data and response compare
   task automatic axr(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] e);
      int k;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      for (k = 0; k < 100; k++) begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      tmo(k);
      check(s_axi_rdata, d);
      check({30'h0, s_axi_rresp}, {30'h0, e});
   endtask : axr

   function automatic int pk(input int i);
      return int'($signed(src[i][16*ch +: 16]));
   endfunction : pk

   function automatic int sat(input int v);
      return v > 32767 ? 32767 : (v < -32768 ? -32768 : v);
   endfunction : sat

   // Expected metered value from the shadowed settings
   function automatic logic [15:0] expv;
      int x;
      int y;
      if (st) x = pk(0);
      else if (!dp) x = pk(1);
      else if (code == 4'hf) x = sat(pk(6) - pk(5));
      else x = map[code] < 0 ? 0 : sat(pk(map[code]) + int'($signed(off)));
      // Notch with zero RAM coefficients: x minus half of (x - x two back)
      y = x;
      if (fl) x = sat(x - ((x - h2) >>> 1));
      h2 = fl ? h1 : 0;
      h1 = fl ? y : 0;
      if (gn) x = sat(x * 16);
      if (rc && x < 0) x = sat(-x);
      return x[15:0];
   endfunction : expv

   // One tick; the expectation is noted as the design takes the sample
   task automatic tick;
      fire <= 1'b1;
      @(posedge aclk);
      fire <= 1'b0;
      @(posedge aclk);
      last = expv();
      q.push_back(last);
      repeat (5) @(posedge aclk);
   endtask : tick

   // Result watcher: oldest note against each metered sample
   always @(posedge aclk) begin
      if (meter_valid) begin
         if (q.size() == 0) check(32'h1, 32'h0);
         else check({16'h0, meter_sample}, {16'h0, q.pop_front()});
      end
   end

   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      axr(8'h20, 32'h2, 2'h0);
      axr(8'h2c, 32'h3, 2'h0);
      axr(8'h1c, 32'h0, 2'h2);
      axw(8'h1c, 32'h5, 2'h2);
      tick();
      // Every input code on every channel; offset random for code 0 only, channel 0 always DC transmit
      for (int i = 0; i < 64; i++) begin
         ch = i[5:4];
         code = i[3:0];
         base = {3'(ch) + 3'h1, 5'h0};
         r = $random(seed);
         st = ch != 0 && r[0];
         dp = ch == 0 || r[1];
         gn = r[2]; // saturation modelled when gain is misused
         rc = r[3];
         off = code == 0 ? r[31:16] : 16'h0;
         axw(8'h00, {30'h0, ch}, 2'h0);
         axw(base, {30'h0, dp, st}, 2'h0);
         axw(base + 8'h04, {28'h0, code}, 2'h0);
         axw(base + 8'h08, {30'h0, rc, gn}, 2'h0);
         axw(base + 8'h10, {16'h0, off}, 2'h0);
         repeat (2) @(posedge aclk);
         check({30'h0, meter_channel_select}, {30'h0, ch});
         check({28'h0, dc_input_select}, {28'h0, code});
         check({31'h0, common_mode_reference},
            {31'h0, code == 4'he && dp && !st});
         tick();
      end
      // Filtered AC on channel 0, notch from the cleared RAM pair
      ch = 0;
      st = 1;
      gn = 0;
      rc = 0;
      fl = 1;
      axw(8'h00, 32'h0, 2'h0);
      axw(8'h20, 32'h5, 2'h0);
      axw(8'h28, 32'h0, 2'h0);
      axw(8'h2c, 32'h2, 2'h0);
      repeat (3) tick();
      axr(8'h04, {16'h0, last}, 2'h0);
      axw(8'h04, 32'h1, 2'h0);
      repeat (5) @(posedge aclk);
      summarize();
   end
endmodule : lmfe_frontend_bench
